// *** rtl/dpwm_code_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpwm_code_filter #(
  parameter int CODE_W = 4,
  parameter int FILTER_TICKS = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic [CODE_W-1:0] raw_code,
  output logic [CODE_W-1:0] stable_code,
  output logic stable
);

  localparam int CNT_W = $clog2(FILTER_TICKS + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_TICKS - 1);

  logic [CODE_W-1:0] cand_q;
  logic [CODE_W-1:0] code_q;
  logic [CNT_W-1:0] cnt_q;
  logic stable_q;

  wire moved = raw_code != cand_q;
  wire settle = tick && (cnt_q == CNT_LAST);

  // Output jumps straight to the settled candidate, never to codes passed on the way
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cand_q <= '0;
      code_q <= '0;
      cnt_q <= '0;
      stable_q <= 1'b0;
    end
    else if (moved)
    begin
      cand_q <= raw_code;
      cnt_q <= '0;
    end
    else if (tick && !settle && cnt_q != CNT_W'(FILTER_TICKS))
    begin
      cnt_q <= cnt_q + 1'b1;
    end
    else if (settle)
    begin
      cnt_q <= cnt_q + 1'b1;
      code_q <= cand_q;
      stable_q <= 1'b1;
    end
  end

  assign stable_code = code_q;
  assign stable = stable_q;

endmodule : dpwm_code_filter
`default_nettype wire

// *** rtl/dpwm_generator.sv ***
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dpwm_generator #(
  parameter int MASTER_DIV = dpwm_pkg::MASTER_DIV,
  parameter int STARTUP_TICKS = dpwm_pkg::STARTUP_TICKS,
  parameter int FILTER_TICKS = dpwm_pkg::FILTER_TICKS,
  parameter dpwm_pkg::dpwm_clamp_type CLAMP_MODE = dpwm_pkg::CLAMP_NONE
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic pwm_out
);

  localparam int LW = dpwm_pkg::LEVEL_W;
  localparam int CW = dpwm_pkg::CODE_W;
  localparam int FW = dpwm_pkg::FRAC_W;
  localparam int PH_W = $clog2(MASTER_DIV * (4 ** dpwm_pkg::MAX_RATIO_LOG4) + 1);
  localparam int PS_W = $clog2(MASTER_DIV + 1);
  localparam int ST_W = $clog2(STARTUP_TICKS + 1);
  localparam int NW = LW + 4;
  localparam int PR_W = PH_W + FW + 1;

  // Bus side state
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic [LW-1:0] div_level_q;
  logic [LW-1:0] duty_level_q;
  logic [LW-1:0] set_ref_q;

  // Timing state
  logic [PS_W-1:0] presc_q;
  logic tick_q;
  logic [ST_W-1:0] startup_q;
  dpwm_pkg::dpwm_state_type state_q;
  logic [CW-1:0] act_code_q;
  logic [PH_W-1:0] phase_q;
  logic [PH_W-1:0] len_q;
  logic [PH_W-1:0] thr_q;
  logic [FW:0] duty_lat_q;
  logic pwm_out_q;
  logic div_busy_q;

  // Filter and divider results
  logic [CW-1:0] filt_code;
  logic filt_stable;
  logic [31:0] quotient;
  logic div_done;

  // Address phase accepted when the bus is ready and this slave is picked
  wire addr_phase = hsel && htrans[1] && hready;
  wire word_write = addr_phase && hwrite && (hsize == dpwm_pkg::HSIZE_WORD);
  wire rd_phase = addr_phase && !hwrite;
  wire [7:0] rd_addr = haddr[7:0];
  wire hit_div = addr_q == dpwm_pkg::REG_DIV_LEVEL;
  wire hit_duty = addr_q == dpwm_pkg::REG_DUTY_LEVEL;
  wire hit_set = addr_q == dpwm_pkg::REG_SET_REF;

  // Status word shows the live code, a waiting code change, run state and pin
  wire code_pending = filt_stable && (filt_code != act_code_q);
  wire running = state_q == dpwm_pkg::ST_RUN;
  wire [31:0] status_w = (32'(act_code_q) << dpwm_pkg::STAT_CODE_LSB)
    | (32'(code_pending) << dpwm_pkg::STAT_PEND_BIT)
    | (32'(running) << dpwm_pkg::STAT_RUN_BIT)
    | (32'(pwm_out_q) << dpwm_pkg::STAT_OUT_BIT);

  // Read mux; unmapped offsets read zero
  wire [31:0] rd_mux = (rd_addr == dpwm_pkg::REG_DIV_LEVEL) ? 32'(div_level_q)
    : (rd_addr == dpwm_pkg::REG_DUTY_LEVEL) ? 32'(duty_level_q)
    : (rd_addr == dpwm_pkg::REG_SET_REF) ? 32'(set_ref_q)
    : (rd_addr == dpwm_pkg::REG_STATUS) ? status_w
    : 32'h0000_0000;

  // Bus pipeline: address captured here, write data taken next cycle
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= '0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= word_write;
      addr_q <= addr_phase ? rd_addr : addr_q;
      hrdata_q <= rd_phase ? rd_mux : 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
  end

  // Writable levels; sub-word writes are dropped since only full words are supported
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_level_q <= dpwm_pkg::DIV_LEVEL_RST;
      duty_level_q <= dpwm_pkg::DUTY_LEVEL_RST;
      set_ref_q <= dpwm_pkg::SET_REF_RST;
    end
    else if (wr_pend_q)
    begin
      div_level_q <= hit_div ? hwdata[LW-1:0] : div_level_q;
      duty_level_q <= hit_duty ? hwdata[LW-1:0] : duty_level_q;
      set_ref_q <= hit_set ? hwdata[LW-1:0] : set_ref_q;
    end
  end

  // Quantise: top four bits of the level fraction, so code k spans k/16..(k+1)/16
  wire [CW-1:0] raw_code = div_level_q[LW-1 -: CW];

  // Master tick, rounded so it never exceeds 1 MHz
  wire presc_wrap = presc_q == PS_W'(MASTER_DIV - 1);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      presc_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      presc_q <= presc_wrap ? '0 : presc_q + 1'b1;
      tick_q <= presc_wrap;
    end
  end

  dpwm_code_filter #(
    .CODE_W(CW),
    .FILTER_TICKS(FILTER_TICKS)
  ) u_filter (
    .ref_clk(ref_clk),
    .srst(srst),
    .tick(tick_q),
    .raw_code(raw_code),
    .stable_code(filt_code),
    .stable(filt_stable)
  );

  // Start-up ends after the tick count and only once a code has settled
  wire startup_full = startup_q == ST_W'(STARTUP_TICKS);
  wire start_go = (state_q == dpwm_pkg::ST_STARTUP) && startup_full && filt_stable;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      startup_q <= '0;
      state_q <= dpwm_pkg::ST_STARTUP;
    end
    else
    begin
      case (state_q)
        dpwm_pkg::ST_STARTUP:
        begin
          startup_q <= (tick_q && !startup_full) ? startup_q + 1'b1 : startup_q;
          state_q <= start_go ? dpwm_pkg::ST_RUN : dpwm_pkg::ST_STARTUP;
        end
        dpwm_pkg::ST_RUN:
        begin
          state_q <= dpwm_pkg::ST_RUN;
        end
        default:
        begin
          state_q <= dpwm_pkg::ST_STARTUP;
        end
      endcase
    end
  end

  // Period boundary; a code change lands only here so no pulse is cut short
  wire phase_wrap = phase_q >= len_q - 1'b1;
  wire period_start = phase_wrap || start_go;
  wire take_code = start_go || (running && code_pending);
  wire [CW-1:0] code_next = take_code ? filt_code : act_code_q;

  // Ratio index mirrors about the midpoint for the inverted half of the codes
  wire [2:0] ratio_next = code_next[dpwm_pkg::INVERT_BIT] ? ~code_next[2:0] : code_next[2:0];
  wire [PH_W-1:0] len_next = PH_W'(MASTER_DIV) << {ratio_next, 1'b0};

  // Duty numerator is ten times modulation minus reference, saturated at both ends
  wire [NW-1:0] mod10 = NW'({duty_level_q, 3'b000}) + NW'({duty_level_q, 1'b0});
  wire [NW-1:0] set_ext = NW'(set_ref_q);
  wire [NW-1:0] set8 = {1'b0, set_ref_q, 3'b000};
  wire [NW-1:0] set9 = set8 + set_ext;
  wire sat_low = mod10 <= set_ext;
  wire sat_high = mod10 >= set9;
  wire [NW-1:0] num_c = sat_low ? '0 : sat_high ? set8 : mod10 - set_ext;

  // Restart only when idle: periods shorter than one division still get a fresh fraction, just later
  wire div_start = period_start && !div_busy_q;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_busy_q <= 1'b0;
    end
    else if (div_start)
    begin
      div_busy_q <= 1'b1;
    end
    else if (div_done)
    begin
      div_busy_q <= 1'b0;
    end
  end

  // Fraction = num / (8 * ref) in 16 fractional bits, i.e. mod/(0.8 ref) - 1/8
  dpwm_serial_div #(
    .DW(32),
    .VW(LW + 3)
  ) u_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(div_start),
    .dividend({num_c, 16'h0000}),
    .divisor(set8[LW+2:0]),
    .quotient(quotient),
    .done(div_done)
  );

  // Latest fraction kept; a zero reference forces zero duty
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      duty_lat_q <= '0;
    end
    else if (div_done)
    begin
      duty_lat_q <= (set_ref_q == '0) ? '0 : quotient[FW:0];
    end
  end

  // Scale the fraction to the coming period length
  wire [PR_W-1:0] thr_prod = PR_W'(duty_lat_q) * PR_W'(len_next);
  wire [PR_W-1:0] lo_prod = PR_W'(dpwm_pkg::LOW_CLAMP_FRAC) * PR_W'(len_next);
  wire [PH_W-1:0] thr_raw = thr_prod[FW +: PH_W];
  wire [PH_W-1:0] lo_lim = lo_prod[FW +: PH_W];
  wire [PH_W-1:0] hi_lim = len_next - lo_lim;
  wire clamp_lo_en = CLAMP_MODE[0];
  wire clamp_hi_en = CLAMP_MODE[1];

  // Variant clamps before inversion, so inversion moves them to the other end
  wire [PH_W-1:0] thr_next = (clamp_lo_en && thr_raw < lo_lim) ? lo_lim
    : (clamp_hi_en && thr_raw > hi_lim) ? hi_lim
    : thr_raw;

  // Period counter; threshold and length change together at the boundary
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      phase_q <= '0;
      len_q <= PH_W'(MASTER_DIV);
      thr_q <= '0;
      act_code_q <= '0;
    end
    else if (period_start)
    begin
      phase_q <= '0;
      len_q <= len_next;
      thr_q <= thr_next;
      act_code_q <= code_next;
    end
    else
    begin
      phase_q <= phase_q + 1'b1;
    end
  end

  // Zero threshold never goes high, full threshold never goes low
  wire pwm_raw = phase_q < thr_q;
  wire invert = act_code_q[dpwm_pkg::INVERT_BIT];
  wire out_d = running ? (pwm_raw ^ invert) : 1'b0;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pwm_out_q <= 1'b0;
    end
    else
    begin
      pwm_out_q <= out_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign pwm_out = pwm_out_q;

endmodule : dpwm_generator
`default_nettype wire

// *** rtl/dpwm_pkg.sv ***
package dpwm_pkg;

  // Clock and master oscillator timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MASTER_PERIOD_NS = 1000;
  localparam int MASTER_DIV = (MASTER_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_TICKS = 500;
  localparam int FILTER_TICKS = 8;
  localparam int MAX_RATIO_LOG4 = 7;

  // Widths and fields
  localparam int LEVEL_W = 12;
  localparam int CODE_W = 4;
  localparam int INVERT_BIT = 3;
  localparam int FRAC_W = 16;
  localparam logic [16:0] LOW_CLAMP_FRAC = 17'h0_0ccd;

  // Register offsets
  localparam logic [7:0] REG_DIV_LEVEL = 8'h00;
  localparam logic [7:0] REG_DUTY_LEVEL = 8'h04;
  localparam logic [7:0] REG_SET_REF = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // Reset values
  localparam logic [11:0] DIV_LEVEL_RST = 12'h080;
  localparam logic [11:0] DUTY_LEVEL_RST = 12'h000;
  localparam logic [11:0] SET_REF_RST = 12'h800;

  // Status field positions
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_PEND_BIT = 4;
  localparam int STAT_RUN_BIT = 8;
  localparam int STAT_OUT_BIT = 9;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    CLAMP_NONE = 2'b00,
    CLAMP_LOW = 2'b01,
    CLAMP_HIGH = 2'b10,
    CLAMP_BOTH = 2'b11
  } dpwm_clamp_type;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'b01,
    ST_RUN = 2'b10
  } dpwm_state_type;

endpackage : dpwm_pkg

// *** rtl/dpwm_serial_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpwm_serial_div #(
  parameter int DW = 32,
  parameter int VW = 15
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [DW-1:0] dividend,
  input wire logic [VW-1:0] divisor,
  output logic [DW-1:0] quotient,
  output logic done
);

  localparam int CW = $clog2(DW + 1);

  logic [VW-1:0] rem_q;
  logic [VW-1:0] den_q;
  logic [DW-1:0] quo_q;
  logic [CW-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  // One restoring step per clock; slow but a single subtractor
  wire [VW:0] shifted = {rem_q, quo_q[DW-1]};
  wire ge = shifted >= {1'b0, den_q};
  wire [VW:0] diff = shifted - {1'b0, den_q};

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rem_q <= '0;
      den_q <= '0;
      quo_q <= '0;
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (start)
    begin
      rem_q <= '0;
      den_q <= divisor;
      quo_q <= dividend;
      cnt_q <= CW'(DW);
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
    else if (busy_q)
    begin
      rem_q <= ge ? diff[VW-1:0] : shifted[VW-1:0];
      quo_q <= {quo_q[DW-2:0], ge};
      cnt_q <= cnt_q - 1'b1;
      busy_q <= cnt_q != CW'(1);
      done_q <= cnt_q == CW'(1);
    end
    else
    begin
      done_q <= 1'b0;
    end
  end

  assign quotient = quo_q;
  assign done = done_q;

endmodule : dpwm_serial_div
`default_nettype wire

// *** test/dpwm_generator_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpwm_generator_tb_top;
  localparam int MD = 4;
  localparam int ST = 5;
  localparam logic [31:0] AD = {24'h00_0000, dpwm_pkg::REG_DIV_LEVEL};
  localparam logic [31:0] AM = {24'h00_0000, dpwm_pkg::REG_DUTY_LEVEL};
  localparam logic [31:0] AS = {24'h00_0000, dpwm_pkg::REG_SET_REF};
  localparam logic [31:0] AT = {24'h00_0000, dpwm_pkg::REG_STATUS};
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic [31:0] hrdata, hi_len, lo_len, edges;
  wire logic hreadyout, hresp, pwm_out;
  wire logic [31:0] hrdata_c, hi_c, lo_c, edges_c;
  wire logic hreadyout_c, hresp_c, pwm_c;
  wire logic hready = hreadyout;
  int errors = 0;
  int samples_checked = 0;
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  dpwm_generator #(.MASTER_DIV(MD), .STARTUP_TICKS(ST), .FILTER_TICKS(2)) dut (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pwm_out(pwm_out));
  dpwm_load_model load (.ref_clk(ref_clk), .srst(srst), .pwm_out(pwm_out), .hi_len(hi_len),
    .lo_len(lo_len), .edges(edges));
  // Twin with both clamps fitted, fed from the same bus, so the variant ends are seen
  dpwm_generator #(.MASTER_DIV(MD), .STARTUP_TICKS(ST), .FILTER_TICKS(2),
    .CLAMP_MODE(dpwm_pkg::CLAMP_BOTH)) dut_clamp (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata_c), .hreadyout(hreadyout_c),
    .hresp(hresp_c), .pwm_out(pwm_c));
  dpwm_load_model load_c (.ref_clk(ref_clk), .srst(srst), .pwm_out(pwm_c), .hi_len(hi_c),
    .lo_len(lo_c), .edges(edges_c));
  task wrap_up;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Period in clock cycles; mirrored codes reuse the same ratio
  function automatic int plen(input int code);
    return MD * (4 ** (code < 8 ? code : 15 - code));
  endfunction : plen
  // High time per period, clamped when asked, inverted for the upper half of codes
  function automatic longint exp_hi(input longint d, input int code, input bit clamp);
    longint num, set, lo;
    set = dpwm_pkg::SET_REF_RST;
    num = 10 * d - set;
    if (num < 0)
      num = 0;
    if (num > 8 * set)
      num = 8 * set;
    num = num * 65536 / (8 * set) * plen(code) / 65536;
    lo = clamp ? longint'(dpwm_pkg::LOW_CLAMP_FRAC) * plen(code) / 65536 : 0;
    if (num < lo)
      num = lo;
    if (num > plen(code) - lo)
      num = plen(code) - lo;
    return (code >= 8) ? plen(code) - num : num;
  endfunction : exp_hi
  // Samples ready before the edge's updates land; the bound catches a stuck slave
  task automatic waitrdy;
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hready !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      errors++;
      wrap_up;
    end
  endtask : waitrdy
  task automatic xfer(input logic w, input logic [2:0] sz, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    waitrdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy;
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, dpwm_pkg::HSIZE_WORD, a, d, r);
  endtask : wr
  task automatic rdc(input string nm, input logic [31:0] a, e, input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] r;
    xfer(1'b0, dpwm_pkg::HSIZE_WORD, a, 32'h0000_0000, r);
    chk(nm, e, r & m);
  endtask : rdc
  task automatic t_reset;
    repeat (ST * MD)
    begin
      @(posedge ref_clk);
      chk("startup", 0, pwm_out);
    end
    rdc("div reset", AD, {20'h0_0000, dpwm_pkg::DIV_LEVEL_RST});
    rdc("duty reset", AM, 32'h0000_0000);
    rdc("ref reset", AS, {20'h0_0000, dpwm_pkg::SET_REF_RST});
    rdc("unmapped", 32'h0000_0010, 32'h0000_0000);
    rdc("status run", AT, 32'h0000_0100);
  endtask : t_reset
  // Ratios 2 to 4 and their mirrors, at an uneven duty so inversion shows
  task automatic t_ratio;
    int codes[6] = '{2, 3, 4, 11, 12, 13};
    int prev, len, n;
    logic [31:0] e0;
    prev = 0;
    wr(AM, 32'h0000_0599);
    foreach (codes[i])
    begin
      len = plen(codes[i]);
      wr(AD, {20'h0_0000, 4'(codes[i]), 8'h80});
      rdc("code held", AT, prev, 32'h0000_000f);
      e0 = edges;
      n = 0;
      while (edges < e0 + 12 && n < 16 * len)
      begin
        @(posedge ref_clk);
        n++;
      end
      if (n >= 16 * len)
      begin
        errors++;
        wrap_up;
      end
      chk("period", len, hi_len + lo_len);
      chk("high time", exp_hi(32'h0000_0599, codes[i], 1'b0), hi_len);
      rdc("code", AT, codes[i], 32'h0000_000f);
      prev = codes[i];
    end
  endtask : t_ratio
  // Saturated levels, one just under the low band edge and one at full scale, stop the output at rest
  task automatic t_sat;
    logic [11:0] dv[3] = '{12'h0cc, 12'hfff, 12'h0cc};
    logic [3:0] cd[3] = '{4'h2, 4'h2, 4'hd};
    logic [31:0] e0;
    logic [31:0] ec;
    foreach (dv[i])
    begin
      wr(AD, {20'h0_0000, cd[i], 8'h80});
      wr(AM, {20'h0_0000, dv[i]});
      repeat (8 * plen(cd[i])) @(posedge ref_clk);
      e0 = edges;
      ec = edges_c;
      repeat (3 * plen(cd[i])) @(posedge ref_clk);
      chk("no toggle", e0, edges);
      chk("rest level", exp_hi(dv[i], cd[i], 1'b0) != 0, pwm_out);
      chk("clamp runs", 1, edges_c != ec);
      chk("clamp high", exp_hi(dv[i], cd[i], 1'b1), hi_c);
      chk("clamp period", plen(cd[i]), hi_c + lo_c);
    end
  endtask : t_sat
  // A byte-sized write must leave the register alone
  task automatic t_size;
    logic [31:0] r;
    wr(AM, 32'h0000_0123);
    xfer(1'b1, 3'h0, AM, 32'h0000_0abc, r);
    rdc("byte write", AM, 32'h0000_0123);
  endtask : t_size
  initial
  begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_ratio;
    t_sat;
    t_size;
    wrap_up;
  end
endmodule : dpwm_generator_tb_top
`default_nettype wire

// *** test/dpwm_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpwm_load_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic pwm_out,
  output logic [31:0] hi_len,
  output logic [31:0] lo_len,
  output logic [31:0] edges
);
  logic [31:0] run_q;
  logic last_q;
  // Length of each finished run; a run still going is never reported
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      run_q <= '0;
      last_q <= 1'b0;
      hi_len <= '0;
      lo_len <= '0;
      edges <= '0;
    end
    else if (pwm_out != last_q)
    begin
      if (last_q)
        hi_len <= run_q;
      else
        lo_len <= run_q;
      run_q <= 32'h0000_0001;
      last_q <= pwm_out;
      edges <= edges + 1;
    end
    else
      run_q <= run_q + 1;
  end
endmodule : dpwm_load_model
`default_nettype wire

// *** test/dpwm_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpwm_properties #(
  parameter int MASTER_DIV = 4,
  parameter int STARTUP_TICKS = 5
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pwm_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Address phases seen on the bus
  wire logic rd_a = hsel && htrans[1] && hready && !hwrite;
  wire logic wr_a = hsel && htrans[1] && hready && hwrite && hsize == dpwm_pkg::HSIZE_WORD
    && haddr[7:0] == dpwm_pkg::REG_DUTY_LEVEL;
  logic wr_q;
  logic [11:0] duty_q;
  int up_q;
  // Shadow of the modulation register; saturating age counter since reset
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wr_q <= 1'b0;
      duty_q <= dpwm_pkg::DUTY_LEVEL_RST;
      up_q <= 0;
    end
    else
    begin
      wr_q <= wr_a;
      if (wr_q)
        duty_q <= hwdata[11:0];
      if (up_q < 100000)
        up_q <= up_q + 1;
    end
  end
  okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  ready_up_a: assert property (!srst |=> hreadyout) else $error("hreadyout low after reset");
  ready_hold_a: assert property ($past(hreadyout) |-> hreadyout) else $error("hreadyout dropped");
  idle_zero_a: assert property (!rd_a |=> hrdata == 32'h0000_0000) else $error("hrdata not zero");
  upper_zero_a: assert property (rd_a |=> hrdata[31:12] == 20'h0_0000) else $error("upper bits set");
  unmapped_zero_a: assert property (rd_a && haddr[7:0] > 8'h0c |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  duty_back_a: assert property (rd_a && haddr[7:0] == dpwm_pkg::REG_DUTY_LEVEL
    |=> hrdata[11:0] == $past(duty_q)) else $error("duty readback wrong");
  startup_low_a: assert property (up_q < STARTUP_TICKS * MASTER_DIV |-> !pwm_out)
    else $error("output active in start-up");
endmodule : dpwm_properties
bind dpwm_generator dpwm_properties #(.MASTER_DIV(MASTER_DIV), .STARTUP_TICKS(STARTUP_TICKS)) u_props (
  .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pwm_out(pwm_out));
`default_nettype wire
